// *** bench/rie_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rie_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // from the exception unit, plus ack_delay from the bench
    input wire rie_pkg::rie_vec_t vec_out,
    input wire logic core_reset,
    input wire logic [3:0] ack_delay,
    // to the exception unit
    output logic instr_boundary,
    output logic vec_ack
);
    logic [1:0] phase;
    logic [3:0] wait_cnt;
    // four-cycle instructions; one boundary pulse every fourth cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= 2'h0;
            instr_boundary <= 1'b0;
        end else begin
            phase <= (core_reset || vec_out.vec_req) ? 2'h0 : phase + 2'h1;
            instr_boundary <= !core_reset && !vec_out.vec_req && &phase;
        end
    end
    // vector taken after ack_delay cycles, one-cycle acknowledge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= 4'h0;
            vec_ack <= 1'b0;
        end else if (vec_out.vec_req && !vec_ack) begin
            wait_cnt <= wait_cnt + 4'h1;
            vec_ack <= wait_cnt >= ack_delay;
        end else begin
            wait_cnt <= 4'h0;
            vec_ack <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** bench/rie_exc_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module rie_exc_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins and core inputs
    input wire logic reset_pin_n,
    input wire logic [rie_pkg::rie_n_src-1:0] src_enable,
    input wire logic instr_boundary,
    input wire logic vec_ack,
    // outputs
    input wire rie_pkg::rie_vec_t vec_out,
    input wire logic push_pc_ccr,
    input wire logic core_reset,
    input wire logic cc_mask,
    input wire logic [rie_pkg::rie_n_src-1:0] req_flags
);
    logic rsvd;
    assign rsvd = vec_out.vec_addr inside {[16'h0002:16'h0007],
        [16'h0012:16'h0013], [16'h0018:16'h001F], [16'h0024:16'h0025],
        [16'h0028:16'h0029]};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rvec;
        vec_out.vec_req && vec_out.is_reset;
    endsequence
    sequence s_rvec_done;
        s_rvec ##0 vec_ack ##1 !instr_boundary;
    endsequence
    a_reset_addr: assert property (s_rvec |-> !vec_out.vec_addr && cc_mask)
        else $error("reset vector wrong");
    a_rvec_start: assert property ($rose(reset_pin_n) |-> ##[1:12] s_rvec)
        else $error("no reset vector after pin release");
    a_pin_halt: assert property ((!reset_pin_n) [*8] |-> core_reset)
        else $error("pin low without reset");
    a_vec_rsvd: assert property (vec_out.vec_req |-> !rsvd && !vec_out.vec_addr[0])
        else $error("reserved vector address");
    a_req_holds: assert property (reset_pin_n [*6] ##0
        (vec_out.vec_req && !vec_ack) |=> vec_out.vec_req &&
        $stable(vec_out.vec_addr))
        else $error("vector request dropped early");
    a_push_mask: assert property (push_pc_ccr |=> !push_pc_ccr ##1 cc_mask)
        else $error("push without mask set");
    a_push_src: assert property (push_pc_ccr |-> vec_out.vec_req &&
        !vec_out.is_reset && req_flags[vec_out.src_idx] &&
        src_enable[vec_out.src_idx])
        else $error("push for an idle source");
    a_masked_quiet: assert property (cc_mask [*3] |=> !push_pc_ccr)
        else $error("accepted while masked");
    a_off_quiet: assert property ((src_enable == '0) [*3] |=> !push_pc_ccr)
        else $error("accepted while disabled");
    a_first_instr: assert property (s_rvec_done |=> !push_pc_ccr)
        else $error("accepted before first instruction");
endmodule
bind rie_exc rie_exc_assertions rie_exc_assertions_inst (
    .clk(clk),
    .rst(rst),
    .reset_pin_n(reset_pin_n),
    .src_enable(src_enable),
    .instr_boundary(instr_boundary),
    .vec_ack(vec_ack),
    .vec_out(vec_out),
    .push_pc_ccr(push_pc_ccr),
    .core_reset(core_reset),
    .cc_mask(cc_mask),
    .req_flags(req_flags)
);
`default_nettype wire

// *** bench/rie_exc_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module rie_exc_tb;
    localparam int unsigned wdt_w = 4;
    typedef struct {
        int src;
        logic [15:0] vec;
    } rie_row_t;
    rie_row_t rows [17] = '{'{0, 16'h0008}, '{1, 16'h000A},
        '{2, 16'h000C}, '{3, 16'h000E}, '{4, 16'h0010}, '{11, 16'h0010},
        '{12, 16'h0014}, '{13, 16'h0016}, '{14, 16'h0020}, '{20, 16'h0020},
        '{21, 16'h0022}, '{23, 16'h0022}, '{24, 16'h0026}, '{25, 16'h002A},
        '{30, 16'h002A}, '{31, 16'h002C}, '{32, 16'h002E}};
    logic clk, rst, reset_pin_n, flag_wr, watchdog_run_wr, watchdog_run_bit;
    logic watchdog_tick, instr_boundary, vec_ack, mask_wr, mask_wdata;
    logic push_pc_ccr, core_reset, periph_reset, cc_mask, rvec_seen;
    logic watchdog_trip_flag, watchdog_run;
    logic [3:0] edge_pins_group_a, edge_sel_a, ack_delay;
    logic [7:0] edge_pins_group_b, edge_sel_b;
    logic [20:0] periph_req;
    logic [32:0] src_enable, flag_wdata, req_flags;
    logic [wdt_w-1:0] watchdog_count;
    rie_pkg::rie_vec_t vec_out;
    int fail_count, n_checks;
    assign rvec_seen = vec_out.vec_req && vec_out.is_reset;
    rie_exc #(.wdt_w(wdt_w)) rie_exc_inst (.clk(clk), .rst(rst),
        .reset_pin_n(reset_pin_n), .edge_pins_group_a(edge_pins_group_a),
        .edge_pins_group_b(edge_pins_group_b), .edge_sel_a(edge_sel_a),
        .edge_sel_b(edge_sel_b), .src_enable(src_enable),
        .periph_req(periph_req), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
        .watchdog_run_wr(watchdog_run_wr),
        .watchdog_run_bit(watchdog_run_bit), .watchdog_tick(watchdog_tick),
        .instr_boundary(instr_boundary), .vec_ack(vec_ack),
        .mask_wr(mask_wr), .mask_wdata(mask_wdata), .vec_out(vec_out),
        .push_pc_ccr(push_pc_ccr), .core_reset(core_reset),
        .periph_reset(periph_reset), .cc_mask(cc_mask),
        .req_flags(req_flags), .watchdog_count(watchdog_count),
        .watchdog_trip_flag(watchdog_trip_flag),
        .watchdog_run(watchdog_run));
    rie_core_model rie_core_model_inst (.clk(clk), .rst(rst),
        .vec_out(vec_out), .core_reset(core_reset), .ack_delay(ack_delay),
        .instr_boundary(instr_boundary), .vec_ack(vec_ack));
    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_hi(ref logic sig, input string what);
        int k;
        k = 0;
        do begin
            cyc(1);
            k++;
        end while (sig !== 1'b1 && k < 40);
        check(what, sig, 1'b1);
    endtask
    task automatic pulse_mask();
        @(posedge clk);
        mask_wr <= 1'b1;
        @(posedge clk);
        mask_wr <= 1'b0;
    endtask
    task automatic wait_rvec();
        wait_hi(rvec_seen, "reset vector");
        check("reset addr", vec_out.vec_addr, 16'h0000);
        check("reset mask", cc_mask, 1'b1);
    endtask
    // pins held five cycles so the synchroniser sees them
    task automatic fire(int src);
        @(posedge clk);
        if (src < 4) edge_pins_group_a[src] <= edge_sel_a[src];
        else if (src < 12) edge_pins_group_b[src-4] <= edge_sel_b[src-4];
        else periph_req[src-12] <= 1'b1;
        @(posedge clk);
        periph_req <= '0;
        repeat (4) @(posedge clk);
        edge_pins_group_a <= ~edge_sel_a;
        edge_pins_group_b <= ~edge_sel_b;
    endtask
    task automatic service(int src, logic [15:0] vec);
        pulse_mask();
        wait_hi(push_pc_ccr, "push");
        check("vector", vec_out.vec_addr, vec);
        check("source", vec_out.src_idx, src);
        cyc(1);
        check("mask set", cc_mask, 1'b1);
        cyc(20);
        check("request", vec_out.vec_req, 1'b0);
        @(posedge clk);
        flag_wr <= 1'b1;
        flag_wdata <= ~(33'h1 << src);
        @(posedge clk);
        flag_wr <= 1'b0;
        cyc(8);
        check("flag", req_flags[src], 1'b0);
    endtask
    task automatic quiet(int n);
        int hits;
        hits = 0;
        repeat (n) begin
            cyc(1);
            if (push_pc_ccr !== 1'b0) hits++;
        end
        check("no vector", hits, 0);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // whole sequence takes about 1000 cycles
    initial begin
        repeat (8000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
    initial begin
        fail_count = 0;
        n_checks = 0;
        rst = 1'b1;
        reset_pin_n = 1'b0;
        edge_sel_a = 4'h5;
        edge_sel_b = 8'h0F;
        edge_pins_group_a = 4'hA;
        edge_pins_group_b = 8'hF0;
        src_enable = '1;
        periph_req = '0;
        flag_wr = 1'b0;
        flag_wdata = '1;
        watchdog_run_wr = 1'b0;
        watchdog_run_bit = 1'b1;
        watchdog_tick = 1'b0;
        mask_wr = 1'b0;
        mask_wdata = 1'b0;
        ack_delay = 4'h0;
        cyc(2);
        check("core reset", core_reset, 1'b1);
        check("flags", req_flags, 33'h0);
        rst <= 1'b0;
        cyc(4);
        reset_pin_n <= 1'b1;
        wait_rvec();
        $display("test reset done");
        foreach (rows[i]) begin
            ack_delay <= (i % 2) ? 4'h5 : 4'h0;
            fire(rows[i].src);
            service(rows[i].src, rows[i].vec);
        end
        $display("test vectors done");
        @(posedge clk);
        periph_req <= 21'h082004;
        @(posedge clk);
        periph_req <= '0;
        service(14, 16'h0020);
        service(25, 16'h002A);
        service(31, 16'h002C);
        $display("test priority done");
        fire(12);
        quiet(20);
        check("masked flag", req_flags[12], 1'b1);
        @(posedge clk);
        flag_wr <= 1'b1;
        flag_wdata <= '1;
        @(posedge clk);
        flag_wr <= 1'b0;
        src_enable <= '0;
        cyc(2);
        check("flag kept", req_flags[12], 1'b1);
        pulse_mask();
        quiet(20);
        src_enable <= '1;
        service(12, 16'h0014);
        $display("test mask done");
        @(posedge clk);
        reset_pin_n <= 1'b0;
        cyc(12);
        check("pin reset", core_reset, 1'b1);
        check("periph reset", periph_reset, 1'b1);
        reset_pin_n <= 1'b1;
        wait_rvec();
        $display("test pin reset done");
        @(posedge clk);
        watchdog_run_wr <= 1'b1;
        @(posedge clk);
        watchdog_run_wr <= 1'b0;
        watchdog_tick <= 1'b1;
        repeat (3) @(posedge clk);
        watchdog_tick <= 1'b0;
        cyc(1);
        check("count", watchdog_count, 3);
        check("run bit", watchdog_run, 1'b1);
        @(posedge clk);
        watchdog_tick <= 1'b1;
        repeat ((1 << wdt_w) - 3) @(posedge clk);
        watchdog_tick <= 1'b0;
        cyc(2);
        check("trip", watchdog_trip_flag, 1'b1);
        check("wd reset", core_reset, 1'b1);
        ack_delay <= 4'hF;
        @(posedge clk);
        watchdog_tick <= 1'b1;
        repeat (1 << wdt_w) @(posedge clk);
        watchdog_tick <= 1'b0;
        wait_rvec();
        check("trip clear", watchdog_trip_flag, 1'b0);
        $display("test watchdog done");
        give_verdict();
    end
endmodule
`default_nettype wire

// *** design/rie_exc.sv ***
`timescale 1ns/1ps
`default_nettype none
module rie_exc #(
    parameter int unsigned wdt_w = rie_pkg::rie_wdt_w
) (
    // clock and power-on reset
    input wire logic clk,
    input wire logic rst,
    // external pins, active low reset
    input wire logic reset_pin_n,
    input wire logic [3:0] edge_pins_group_a,
    input wire logic [7:0] edge_pins_group_b,
    // edge selects, one means rising
    input wire logic [3:0] edge_sel_a,
    input wire logic [7:0] edge_sel_b,
    // per-source enables and peripheral request pulses
    input wire logic [rie_pkg::rie_n_src-1:0] src_enable,
    input wire logic [rie_pkg::rie_n_src-rie_pkg::rie_n_ext-1:0] periph_req,
    // flag write port: a zero bit clears
    input wire logic flag_wr,
    input wire logic [rie_pkg::rie_n_src-1:0] flag_wdata,
    // watchdog control
    input wire logic watchdog_run_wr,
    input wire logic watchdog_run_bit,
    input wire logic watchdog_tick,
    // core side
    input wire logic instr_boundary,
    input wire logic vec_ack,
    input wire logic mask_wr,
    input wire logic mask_wdata,
    output rie_pkg::rie_vec_t vec_out,
    output logic push_pc_ccr,
    output logic core_reset,
    output logic periph_reset,
    output logic cc_mask,
    // status
    output logic [rie_pkg::rie_n_src-1:0] req_flags,
    output logic [wdt_w-1:0] watchdog_count,
    output logic watchdog_trip_flag,
    output logic watchdog_run
);
    initial begin
        if (wdt_w < 2 || wdt_w > 16) begin
            $error("rie_exc: wdt_w out of range");
        end
    end

    localparam int unsigned n_src = rie_pkg::rie_n_src;
    localparam int unsigned n_ext = rie_pkg::rie_n_ext;

    rie_pkg::rie_state_t state;
    logic reset_pin_lvl;
    logic [n_ext-1:0] ext_lvl;
    logic [n_ext-1:0] ext_prev;
    logic [n_ext-1:0] ext_sel;
    logic [n_ext-1:0] ext_hit;
    logic [n_src-1:0] set_vec;
    logic [n_src-1:0] pend;
    logic any_pend;
    logic [5:0] win;
    logic [15:0] win_vec;
    logic wdt_ovf;
    logic in_reset;
    logic first_instr;

    rie_sync #(.width(1), .init(1'b0)) u_sync_rst (
        .clk(clk),
        .rst(rst),
        .pin(reset_pin_n),
        .level(reset_pin_lvl)
    );

    rie_sync #(.width(n_ext), .init('1)) u_sync_ext (
        .clk(clk),
        .rst(rst),
        .pin({edge_pins_group_b, edge_pins_group_a}),
        .level(ext_lvl)
    );

    assign ext_sel = {edge_sel_b, edge_sel_a};

    // edge detect; the previous level is held in reset too so no false edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_prev <= '1;
        end else begin
            ext_prev <= ext_lvl;
        end
    end

    genvar i;
    generate
        for (i = 0; i < n_ext; i++) begin : g_edge
            assign ext_hit[i] = ext_sel[i] ? (ext_lvl[i] & ~ext_prev[i])
                : (~ext_lvl[i] & ext_prev[i]);
        end
    endgenerate

    assign set_vec = {periph_req, ext_hit};

    // reset state held by the pin or by a watchdog trip
    assign in_reset = ~reset_pin_lvl
        | (watchdog_trip_flag & ~wdt_ovf & (state == rie_pkg::rie_st_reset));

    // request flags: set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_flags <= '0;
        end else if (state == rie_pkg::rie_st_reset) begin
            req_flags <= '0;
        end else if (flag_wr) begin
            req_flags <= (req_flags & flag_wdata) | set_vec;
        end else begin
            req_flags <= req_flags | set_vec;
        end
    end

    assign pend = req_flags & src_enable;

    // fixed priority: lowest index wins
    always_comb begin
        win = 6'h00;
        any_pend = 1'b0;
        for (int k = n_src - 1; k >= 0; k--) begin
            if (pend[k]) begin
                win = 6'(k);
                any_pend = 1'b1;
            end
        end
    end

    // vector table; shared groups map to one entry
    always_comb begin
        if (win < 6'(rie_pkg::rie_src_grpb)) begin
            win_vec = rie_pkg::rie_vec_grpa0
                + 16'(win) * rie_pkg::rie_vec_step;
        end else if (win < 6'(rie_pkg::rie_src_tima)) begin
            win_vec = rie_pkg::rie_vec_grpb;
        end else if (win == 6'(rie_pkg::rie_src_tima)) begin
            win_vec = rie_pkg::rie_vec_tima;
        end else if (win == 6'(rie_pkg::rie_src_timb)) begin
            win_vec = rie_pkg::rie_vec_timb;
        end else if (win < 6'(rie_pkg::rie_src_cmp)) begin
            win_vec = rie_pkg::rie_vec_cap;
        end else if (win < 6'(rie_pkg::rie_src_csu)) begin
            win_vec = rie_pkg::rie_vec_cmp;
        end else if (win == 6'(rie_pkg::rie_src_csu)) begin
            win_vec = rie_pkg::rie_vec_csu;
        end else if (win < 6'(rie_pkg::rie_src_adc)) begin
            win_vec = rie_pkg::rie_vec_asu;
        end else if (win == 6'(rie_pkg::rie_src_adc)) begin
            win_vec = rie_pkg::rie_vec_adc;
        end else begin
            win_vec = rie_pkg::rie_vec_dxf;
        end
    end

    // watchdog run bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            watchdog_run <= 1'b0;
        end else if (~reset_pin_lvl) begin
            watchdog_run <= 1'b0;
        end else if (watchdog_run_wr) begin
            watchdog_run <= watchdog_run_bit;
        end
    end

    assign wdt_ovf = watchdog_run & watchdog_tick & (&watchdog_count);

    // watchdog counter keeps running through its own reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            watchdog_count <= '0;
        end else if (~reset_pin_lvl) begin
            watchdog_count <= '0;
        end else if (watchdog_run & watchdog_tick) begin
            watchdog_count <= watchdog_count + 1'b1;
        end
    end

    // trip flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            watchdog_trip_flag <= 1'b0;
        end else if (~reset_pin_lvl) begin
            watchdog_trip_flag <= 1'b0;
        end else if (wdt_ovf & ~watchdog_trip_flag) begin
            watchdog_trip_flag <= 1'b1;
        end else if (wdt_ovf & watchdog_trip_flag) begin
            watchdog_trip_flag <= 1'b0;
        end
    end

    // exception sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= rie_pkg::rie_st_reset;
        end else if (~reset_pin_lvl) begin
            state <= rie_pkg::rie_st_reset;
        end else if (wdt_ovf & ~watchdog_trip_flag) begin
            state <= rie_pkg::rie_st_reset;
        end else begin
            case (state)
                rie_pkg::rie_st_reset: begin
                    if (~in_reset) begin
                        state <= rie_pkg::rie_st_rvec;
                    end
                end
                rie_pkg::rie_st_rvec: begin
                    if (vec_ack) begin
                        state <= rie_pkg::rie_st_run;
                    end
                end
                rie_pkg::rie_st_run: begin
                    if (instr_boundary & any_pend & ~cc_mask
                        & ~first_instr) begin
                        state <= rie_pkg::rie_st_ivec;
                    end
                end
                rie_pkg::rie_st_ivec: begin
                    if (vec_ack) begin
                        state <= rie_pkg::rie_st_run;
                    end
                end
                default: begin
                    state <= rie_pkg::rie_st_reset;
                end
            endcase
        end
    end

    // first instruction after reset always runs unmasked by nothing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_instr <= 1'b1;
        end else if (state == rie_pkg::rie_st_reset) begin
            first_instr <= 1'b1;
        end else if (state == rie_pkg::rie_st_run && instr_boundary) begin
            first_instr <= 1'b0;
        end
    end

    // mask bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cc_mask <= 1'b1;
        end else if (state == rie_pkg::rie_st_reset
            || state == rie_pkg::rie_st_rvec) begin
            cc_mask <= 1'b1;
        end else if (state == rie_pkg::rie_st_ivec) begin
            cc_mask <= 1'b1;
        end else if (mask_wr) begin
            cc_mask <= mask_wdata;
        end
    end

    // vector output, latched on entry and held until acknowledged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vec_out <= '0;
        end else if (state == rie_pkg::rie_st_reset) begin
            vec_out <= '0;
            if (~in_reset && reset_pin_lvl
                && !(wdt_ovf & ~watchdog_trip_flag)) begin
                vec_out.vec_req <= 1'b1;
                vec_out.is_reset <= 1'b1;
                vec_out.vec_addr <= rie_pkg::rie_vec_reset;
            end
        end else if (vec_ack) begin
            vec_out.vec_req <= 1'b0;
        end else if (state == rie_pkg::rie_st_run && ~reset_pin_lvl) begin
            vec_out <= '0;
        end else if (state == rie_pkg::rie_st_run && instr_boundary
            && any_pend && ~cc_mask && ~first_instr
            && reset_pin_lvl && !wdt_ovf) begin
            vec_out.vec_req <= 1'b1;
            vec_out.is_reset <= 1'b0;
            vec_out.vec_addr <= win_vec;
            vec_out.src_idx <= win;
        end
    end

    // push strobe for the interrupt entry
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            push_pc_ccr <= 1'b0;
        end else begin
            push_pc_ccr <= state == rie_pkg::rie_st_run && instr_boundary
                && any_pend && ~cc_mask && ~first_instr
                && reset_pin_lvl && !wdt_ovf;
        end
    end

    // resets out
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_reset <= 1'b1;
            periph_reset <= 1'b1;
        end else begin
            core_reset <= in_reset
                | (wdt_ovf & ~watchdog_trip_flag);
            periph_reset <= in_reset
                | (wdt_ovf & ~watchdog_trip_flag);
        end
    end
endmodule
`default_nettype wire

// *** design/rie_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// three-stage pin synchroniser; output moves when stages two and three agree
module rie_sync #(
    parameter int unsigned width = 1,
    parameter logic [width-1:0] init = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins
    input wire logic [width-1:0] pin,
    output logic [width-1:0] level
);
    logic [width-1:0] s1;
    logic [width-1:0] s2;
    logic [width-1:0] s3;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= init;
            s2 <= init;
            s3 <= init;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    genvar i;
    generate
        for (i = 0; i < width; i++) begin : g_bit
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    level[i] <= init[i];
                end else if (s2[i] == s3[i]) begin
                    level[i] <= s3[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** shared/rie_pkg.sv ***
// Notes on behaviour
// - reset outranks everything; its vector fetch starts right after reset clears.
// - interrupt vectoring waits for the current instruction or exception to finish.
// - reset pin low stops all processing at once and holds the reset state.
// - reset vectoring starts when the pin returns high after the low period.
// - reset initialises internal state and peripherals and sets the mask bit.
// - program counter loads from the reset vector word at address zero.
// - watchdog counts up once its run bit is written to one.
// - watchdog overflow sets the trip flag and enters the reset state.
// - with trip flag set, next overflow releases reset and vectors as a pin reset.
// - after reset vectoring all interrupts stay masked for the first instruction.
// - twelve external and twenty-one internal request sources are accepted.
// - among pending requests the highest fixed priority is served first.
// - with mask bit set, flags still latch but nothing is accepted.
// - each external pin picks rising or falling edge on its own.
// - group a pins vector 4 to 7, group b shares 8, timers 10 and 11.
// - capture timer's seven requests share vector 16.
// - second timer shares vector 17; clocked serial unit uses vector 19.
// - async serial unit shares 21; conversion end 22; direct transfer 23 lowest.
// - reserved vector locations are never produced.
// - request flags clear on a written zero; a written one does nothing.
// - a source with its enable bit clear never reaches the core.
package rie_pkg;
    localparam int unsigned rie_n_src = 33;
    localparam int unsigned rie_n_ext = 12;
    localparam int unsigned rie_n_grp = 12;
    localparam int unsigned rie_clk_mhz = 200;
    localparam int unsigned rie_vec_w = 16;
    localparam int unsigned rie_wdt_w = 8;

    // source indices, highest priority first
    localparam int unsigned rie_src_grpa = 0;
    localparam int unsigned rie_src_grpb = 4;
    localparam int unsigned rie_src_tima = 12;
    localparam int unsigned rie_src_timb = 13;
    localparam int unsigned rie_src_cap = 14;
    localparam int unsigned rie_src_cmp = 21;
    localparam int unsigned rie_src_csu = 24;
    localparam int unsigned rie_src_asu = 25;
    localparam int unsigned rie_src_adc = 31;
    localparam int unsigned rie_src_dxf = 32;

    localparam logic [15:0] rie_vec_reset = 16'h0000;
    localparam logic [15:0] rie_vec_grpa0 = 16'h0008;
    localparam logic [15:0] rie_vec_grpb = 16'h0010;
    localparam logic [15:0] rie_vec_tima = 16'h0014;
    localparam logic [15:0] rie_vec_timb = 16'h0016;
    localparam logic [15:0] rie_vec_cap = 16'h0020;
    localparam logic [15:0] rie_vec_cmp = 16'h0022;
    localparam logic [15:0] rie_vec_csu = 16'h0026;
    localparam logic [15:0] rie_vec_asu = 16'h002A;
    localparam logic [15:0] rie_vec_adc = 16'h002C;
    localparam logic [15:0] rie_vec_dxf = 16'h002E;
    localparam logic [15:0] rie_vec_step = 16'h0002;

    localparam int unsigned rie_pin_min_cyc = 10;

    typedef enum logic [1:0] {
        rie_st_reset = 2'b00,
        rie_st_rvec = 2'b01,
        rie_st_run = 2'b10,
        rie_st_ivec = 2'b11
    } rie_state_t;

    // request to the core
    typedef struct packed {
        logic vec_req;
        logic is_reset;
        logic [15:0] vec_addr;
        logic [5:0] src_idx;
    } rie_vec_t;
endpackage
